// ### dv/mcq_gen_model.sv
// Profile generator stand-in: each start runs LEN cycles, then done.
// Assumes starts come only from the queue, one run per axis.
`timescale 1ns/100ps
module mcq_gen_model #(parameter [7:0] LEN = 8'h10) (
  input  wire       i_clk,   // Clock
  input  wire       i_rst,   // Sync reset, active high
  input  wire [3:0] i_start, // Starts
  output reg  [3:0] o_done   // Dones
);
  reg [7:0] cnt_reg [0:3];
  integer   k;
  always @(posedge i_clk) begin
    for (k = 0; k < 4; k = k + 1) begin
      if (i_rst) begin
        o_done[k]  <= 1'b0;
        cnt_reg[k] <= 8'h00;
      end else begin
        o_done[k] <= (cnt_reg[k] == 8'h01);
        if (i_start[k]) cnt_reg[k] <= LEN;
        else if (cnt_reg[k] != 8'h00) cnt_reg[k] <= cnt_reg[k] - 8'h01;
      end
    end
  end
endmodule

// ### dv/mcq_queue_properties.sv
// Checks axis 0 of the queue at the top ports; the two gating checks cover all four axes.
// Assumes outputs land one cycle after the causing edge.
`timescale 1ns/100ps
`include "mcq_defs.vh"
module mcq_queue_chk (
  input wire        i_clk,     // Clock
  input wire        i_sys_rst, // Reset
  input wire [3:0]  i_wr,      // Writes
  input wire [3:0]  i_done,    // Dones
  input wire        i_int_en,  // Int enable
  input wire        i_fac_pre, // Factor
  input wire [3:0]  o_start,   // Starts
  input wire [11:0] o_status,  // Occupancy
  input wire [3:0]  o_ev,      // Events
  input wire [3:0]  o_cmp      // Completes
);
  default clocking @(posedge i_clk); endclocking
  default disable iff (i_sys_rst);
  wire [2:0] s = o_status[2:0];
  wire       w = i_wr[0];
  wire       d = i_done[0];
  property p_load; w && s == 3'h0 |=> o_start[0] && s == 3'h1; endproperty
  a_load: assert property (p_load) else $error("load");
  property p_adv; w && !d && s == 3'h1 |=> s == 3'h3; endproperty
  a_adv: assert property (p_adv) else $error("advance");
  property p_next; d && !w && s == 3'h3 |=> o_start[0] && s == 3'h1; endproperty
  a_next: assert property (p_next) else $error("next");
  property p_shift; d && !w && s == 3'h7 |=> o_start[0] && s == 3'h3; endproperty
  a_shift: assert property (p_shift) else $error("shift");
  property p_ovr; w && !d && s == 3'h7 |=> !o_start[0] && s == 3'h7; endproperty
  a_ovr: assert property (p_ovr) else $error("overwrite");
  property p_cmp; d && !w && i_int_en && s == 3'h1 |=> o_cmp[0] && s == 3'h0; endproperty
  a_cmp: assert property (p_cmp) else $error("complete");
  property p_ev; w && i_int_en && i_fac_pre && s == 3'h0 |=> o_ev[0]; endproperty
  a_ev: assert property (p_ev) else $error("event");
  property p_iso; !w && !d |=> $stable(s); endproperty
  a_iso: assert property (p_iso) else $error("isolation");
  property p_ev_off; !(i_int_en && i_fac_pre) |=> o_ev == 4'h0; endproperty
  a_ev_off: assert property (p_ev_off) else $error("event gated");
  property p_cmp_off; !i_int_en |=> o_cmp == 4'h0; endproperty
  a_cmp_off: assert property (p_cmp_off) else $error("complete gated");
endmodule
bind mcq_queue mcq_queue_chk chk_u (.i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_wr(i_wr),
  .i_done(i_done), .i_int_en(i_int_en), .i_fac_pre(i_fac_pre), .o_start(o_start),
  .o_status(o_status), .o_ev(o_ev), .o_cmp(o_cmp));

// ### dv/testbench.sv
// Bench for the queue: chained writes, overwrite, event gating.
// Assumes the generator model closes each run after LEN cycles.
`timescale 1ns/100ps
`include "mcq_defs.vh"
module testbench;
  reg          i_clk, i_sys_rst = 1'b1, i_int_en = 1'b1, i_fac_pre = 1'b1, seen;
  reg  [3:0]   i_wr = 4'h0;
  reg  [11:0]  i_op = 12'h000, starts;
  reg  [255:0] i_cmd = 256'h0;
  reg  [2:0]   last_op;
  reg  [63:0]  last_cmd;
  reg  [11:0]  evs;
  wire [3:0]   done, o_start, o_ev, o_cmp;
  wire [11:0]  o_op, o_status;
  wire [255:0] o_cmd;
  integer      error_cnt = 0, total_checks = 0, cyc = 0, n;
  mcq_queue dut_u (.i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_wr(i_wr), .i_op(i_op),
    .i_cmd(i_cmd), .i_done(done), .i_int_en(i_int_en), .i_fac_pre(i_fac_pre),
    .o_start(o_start), .o_op(o_op), .o_cmd(o_cmd), .o_status(o_status), .o_ev(o_ev),
    .o_cmp(o_cmp));
  mcq_gen_model #(.LEN(8'h10)) gen_u (.i_clk(i_clk), .i_rst(i_sys_rst), .i_start(o_start),
    .o_done(done));
  initial begin
    i_clk = 1'b0;
    forever #4 i_clk = ~i_clk;
  end
  task chk(input string nm, input [11:0] exp, input [11:0] got);
    total_checks = total_checks + 1;
    if (got !== exp) begin
      error_cnt = error_cnt + 1;
      $display("Error %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task wr(input integer g, input [2:0] op);
    @(posedge i_clk);
    i_wr[g] <= 1'b1;
    i_op[g*3 +: 3] <= op;
    // Relative moves, zero ramp times: junction velocities match
    i_cmd[g*64 +: 64] <= {op, 58'h0, op};
    @(posedge i_clk);
    i_wr[g] <= 1'b0;
    #1;
  endtask
  // Count starts until the completion pulse, bounded
  task run(input integer g);
    starts = 12'h000;
    seen = 1'b0;
    evs = 12'h000;
    for (n = 0; n < 300 && !seen; n = n + 1) begin
      @(posedge i_clk);
      #1;
      if (o_start[g] === 1'b1) starts = starts + 12'h001;
      if (o_start[g] === 1'b1) last_op = o_op[g*3 +: 3];
      if (o_start[g] === 1'b1) last_cmd = o_cmd[g*64 +: 64];
      if (o_ev[g] === 1'b1) evs = evs + 12'h001;
      seen = (o_cmp[g] === 1'b1);
    end
  endtask
  task close_out;
    $display("checks %0d errors %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  always @(posedge i_clk) begin
    cyc <= cyc + 1;
    if (cyc == 2000) begin
      error_cnt = error_cnt + 1;
      close_out;
    end
  end
  initial begin
    repeat (5) @(posedge i_clk);
    i_sys_rst <= 1'b0;
    #1 chk("status", 12'h000, o_status);
    chk("start", 12'h000, o_start);
    // Single-axis chain only; mixed axis counts are never chained
    wr(0, `MCQ_OP_TRAP);
    chk("status", 12'h001, o_status);
    chk("event", 12'h001, o_ev);
    wr(0, `MCQ_OP_SCURVE);
    chk("status", 12'h003, o_status);
    chk("event", 12'h001, o_ev);
    wr(0, `MCQ_OP_TRAP);
    chk("status", 12'h007, o_status);
    chk("event", 12'h000, o_ev);
    wr(0, `MCQ_OP_SCURVE);
    chk("status", 12'h007, o_status);
    run(0);
    chk("starts", 12'h002, starts);
    chk("events", 12'h001, evs);
    chk("last op", {9'h000, `MCQ_OP_SCURVE}, {9'h000, last_op});
    chk("last cmd", {6'h00, `MCQ_OP_SCURVE, `MCQ_OP_SCURVE},
      {6'h00, last_cmd[63:61], last_cmd[2:0]});
    chk("complete", 12'h001, seen);
    $display("chain test done");
    wr(1, `MCQ_OP_LINE4);
    wr(1, `MCQ_OP_LINE4);
    chk("status", 12'h018, o_status);
    run(1);
    chk("starts", 12'h001, starts);
    chk("last op", {9'h000, `MCQ_OP_LINE4}, {9'h000, last_op});
    chk("complete", 12'h001, seen);
    $display("four-axis chain test done");
    @(posedge i_clk);
    i_fac_pre <= 1'b0;
    wr(2, `MCQ_OP_ARC);
    chk("status", 12'h040, o_status);
    chk("event", 12'h000, o_ev);
    run(2);
    chk("complete", 12'h001, seen);
    chk("events", 12'h000, evs);
    $display("gating test done");
    @(posedge i_clk);
    i_int_en <= 1'b0;
    wr(3, `MCQ_OP_LINE);
    chk("status", 12'h200, o_status);
    run(3);
    chk("complete", 12'h000, seen);
    chk("status", 12'h000, o_status);
    $display("enable test done");
    close_out;
  end
endmodule

// ### include/mcq_defs.vh
// Constants for the per-axis motion command queue.
// Included by the queue design; no other dependencies.
`ifndef MCQ_DEFS_VH
`define MCQ_DEFS_VH
`define MCQ_AXES      4
`define MCQ_AXW       2
`define MCQ_CMDW      64
`define MCQ_OPW       3
// Operation kinds carried with each entry
`define MCQ_OP_TRAP   3'h0
`define MCQ_OP_SCURVE 3'h1
`define MCQ_OP_LINE   3'h2
`define MCQ_OP_ARC    3'h3
`define MCQ_OP_LINE3  3'h4
`define MCQ_OP_LINE4  3'h5
// Occupancy status bit positions
`define MCQ_ST_ACT    0
`define MCQ_ST_PRE1   1
`define MCQ_ST_PRE2   2
`endif

// ### verilog/mcq_queue.v
// Per-axis three-stage command queue: active, first and second stage.
// Assumes an external profile generator that starts on a start pulse and
// reports completion with a one-cycle done pulse per axis.
// Host writes are taken as synchronous to the clock; a done while idle is dropped.
// Operation kinds are carried, never decoded; chaining rules stay with the host.
// Overview of operation
// - Host writes each new operation into second stage of target axis.
// - Active and first empty: second stage goes straight to active and starts.
// - Active busy, first empty: second stage advances into first stage.
// - On completion load first stage into active and shift second down in the same cycle.
// - Next operation's start pulse comes one cycle after the previous done pulse.
// - Event raised when the second stage becomes empty, if enabled.
// - Interrupt raised when queued operations have all completed.
// - Write into an occupied second stage replaces its entry.
// - Each axis has its own queue; no cross-axis continuation.
// - Trapezoid, S-curve, linear and circular moves share the queue.
// - Queue occupancy is exposed as pollable status.
// - Three and four axis linear chains are accepted.
`timescale 1ns/100ps
`include "mcq_defs.vh"

module mcq_axis (
  input  wire                 i_clk,      // System clock
  input  wire                 i_sys_rst,  // Sync reset, active high
  input  wire                 i_wr,       // Write into second stage
  input  wire [`MCQ_OPW-1:0]  i_op,       // Operation kind
  input  wire [`MCQ_CMDW-1:0] i_cmd,      // Operation parameters
  input  wire                 i_done,     // Running operation finished
  input  wire                 i_ev_en,    // Stage-empty event enable
  input  wire                 i_cmp_en,   // Completion interrupt enable
  output reg                  o_start,    // Start pulse to generator
  output reg  [`MCQ_OPW-1:0]  o_op,       // Active operation kind
  output reg  [`MCQ_CMDW-1:0] o_cmd,      // Active operation parameters
  output reg  [2:0]           o_status,   // Occupancy: act, pre1, pre2
  output reg                  o_ev,       // Stage-empty event pulse
  output reg                  o_cmp       // All-complete pulse
);
  // Occupancy flags, one per stage
  reg                 act_reg;
  reg                 p1_reg;
  reg                 p2_reg;
  // Stored entries of both waiting stages
  reg [`MCQ_OPW-1:0]  p1_op_reg;
  reg [`MCQ_CMDW-1:0] p1_cmd_reg;
  reg [`MCQ_OPW-1:0]  p2_op_reg;
  reg [`MCQ_CMDW-1:0] p2_cmd_reg;

  reg                  act_next;
  reg                  p1_next;
  reg                  p2_next;
  reg                  load_p1;
  reg                  load_p2_act;
  reg                  mv_p2_p1;

  wire                 done_v;
  wire                 act_free;
  wire                 p2_has;
  wire [`MCQ_OPW-1:0]  p2_op;
  wire [`MCQ_CMDW-1:0] p2_cmd;
  wire                 start_next;
  wire                 ev_next;
  wire                 cmp_next;

  // Done only meaningful while active; ignore stray pulses
  assign done_v   = i_done & act_reg;
  assign act_free = ~act_reg | done_v;
  // Second stage content present this cycle, including a fresh write
  assign p2_has = p2_reg | i_wr;
  assign p2_op  = i_wr ? i_op : p2_op_reg;
  assign p2_cmd = i_wr ? i_cmd : p2_cmd_reg;
  assign start_next = load_p1 | load_p2_act;
  // A write that leaves stage two at once still frees it for the host
  assign ev_next  = i_ev_en & p2_has & ~p2_next;
  // Completion only when nothing follows; a zero-gap reload is not an end
  assign cmp_next = i_cmp_en & done_v & ~act_next;
  always @* begin
    // Defaults: hold, and drop an active entry that just finished
    load_p1     = 1'b0;
    load_p2_act = 1'b0;
    mv_p2_p1    = 1'b0;
    act_next    = act_reg & ~done_v;
    p1_next     = p1_reg;
    p2_next     = p2_has;
    // Stage one is older than stage two, so it goes first
    if (act_free && p1_reg) begin
      load_p1  = 1'b1;
      act_next = 1'b1;
      p1_next  = p2_has;
      mv_p2_p1 = p2_has;
      p2_next  = 1'b0;
    end else if (act_free && p2_has) begin
      // Nothing waits ahead: skip stage one for a zero-gap start
      load_p2_act = 1'b1;
      act_next    = 1'b1;
      p2_next     = 1'b0;
    end else if (!p1_reg && p2_has) begin
      // Active busy: the entry waits in stage one
      mv_p2_p1 = 1'b1;
      p1_next  = 1'b1;
      p2_next  = 1'b0;
    end
  end

  // Occupancy flags
  always @(posedge i_clk) begin
    if (i_sys_rst) begin
      act_reg <= 1'b0;
      p1_reg  <= 1'b0;
      p2_reg  <= 1'b0;
    end else begin
      act_reg <= act_next;
      p1_reg  <= p1_next;
      p2_reg  <= p2_next;
    end
  end

  // Stage two data; written on every write, even one that moves on at once
  always @(posedge i_clk) begin
    if (i_sys_rst) begin
      p2_op_reg  <= `MCQ_OP_TRAP;
      p2_cmd_reg <= {`MCQ_CMDW{1'b0}};
    end else if (i_wr) begin
      p2_op_reg  <= i_op;
      p2_cmd_reg <= i_cmd;
    end
  end

  // Stage one data
  always @(posedge i_clk) begin
    if (i_sys_rst) begin
      p1_op_reg  <= `MCQ_OP_TRAP;
      p1_cmd_reg <= {`MCQ_CMDW{1'b0}};
    end else if (mv_p2_p1) begin
      p1_op_reg  <= p2_op;
      p1_cmd_reg <= p2_cmd;
    end
  end

  // Active entry handed to the generator
  always @(posedge i_clk) begin
    if (i_sys_rst) begin
      o_start <= 1'b0;
      o_op    <= `MCQ_OP_TRAP;
      o_cmd   <= {`MCQ_CMDW{1'b0}};
    end else begin
      o_start <= start_next;
      if (load_p1) begin
        o_op  <= p1_op_reg;
        o_cmd <= p1_cmd_reg;
      end else if (load_p2_act) begin
        o_op  <= p2_op;
        o_cmd <= p2_cmd;
      end
    end
  end

  // Status mirrors next occupancy, so it matches the flags cycle for cycle
  always @(posedge i_clk) begin
    if (i_sys_rst) begin
      o_status <= 3'h0;
      o_ev     <= 1'b0;
      o_cmp    <= 1'b0;
    end else begin
      o_status[`MCQ_ST_ACT]  <= act_next;
      o_status[`MCQ_ST_PRE1] <= p1_next;
      o_status[`MCQ_ST_PRE2] <= p2_next;
      o_ev  <= ev_next;
      o_cmp <= cmp_next;
    end
  end
endmodule

module mcq_queue (
  input  wire                            i_clk,     // System clock
  input  wire                            i_sys_rst, // Sync reset, active high
  input  wire [`MCQ_AXES-1:0]            i_wr,      // Per-axis write strobe
  input  wire [`MCQ_AXES*`MCQ_OPW-1:0]   i_op,      // Per-axis operation kind
  input  wire [`MCQ_AXES*`MCQ_CMDW-1:0]  i_cmd,     // Per-axis parameters
  input  wire [`MCQ_AXES-1:0]            i_done,    // Per-axis completion
  input  wire                            i_int_en,  // Global interrupt enable
  input  wire                            i_fac_pre, // Factor: stage empty
  output wire [`MCQ_AXES-1:0]            o_start,   // Per-axis start pulse
  output wire [`MCQ_AXES*`MCQ_OPW-1:0]   o_op,      // Per-axis active kind
  output wire [`MCQ_AXES*`MCQ_CMDW-1:0]  o_cmd,     // Per-axis active params
  output wire [`MCQ_AXES*3-1:0]          o_status,  // Per-axis occupancy
  output wire [`MCQ_AXES-1:0]            o_ev,      // Per-axis stage-empty event
  output wire [`MCQ_AXES-1:0]            o_cmp      // Per-axis all-complete
);
  wire ev_en;  // Stage-empty event gate
  wire cmp_en; // Completion gate

  // Only the stage-empty event also needs its factor bit
  assign ev_en  = i_int_en & i_fac_pre;
  assign cmp_en = i_int_en;

  // Axis queues never share state; a chain stays on its own axis
  genvar g;
  generate
    for (g = 0; g < `MCQ_AXES; g = g + 1) begin : ax
      // Independent queue per axis
      mcq_axis u_axis (
        .i_clk    (i_clk),
        .i_sys_rst(i_sys_rst),
        .i_wr     (i_wr[g]),
        .i_op     (i_op[g*`MCQ_OPW +: `MCQ_OPW]),
        .i_cmd    (i_cmd[g*`MCQ_CMDW +: `MCQ_CMDW]),
        .i_done   (i_done[g]),
        .i_ev_en  (ev_en),
        .i_cmp_en (cmp_en),
        .o_start  (o_start[g]),
        .o_op     (o_op[g*`MCQ_OPW +: `MCQ_OPW]),
        .o_cmd    (o_cmd[g*`MCQ_CMDW +: `MCQ_CMDW]),
        .o_status (o_status[g*3 +: 3]),
        .o_ev     (o_ev[g]),
        .o_cmp    (o_cmp[g])
      );
    end
  endgenerate
endmodule
